// ==== src/home_pwm_pin_function_mux.sv ====
// Pin function mux for the home pin, PWM group A outputs, current-status and fault inputs.
`include "pin_mux_map.svh"

module home_pwm_pin_function_mux (
    input  wire logic                      mclk,                // 100 MHz clock
    input  wire logic                      rst,                 // Async reset, active high
    input  wire logic                      homeAlternateSelect, // Home pin to SPI select
    input  wire logic                      timerBSelect,        // Home pin to timer B ch 3
    input  wire logic [3:0]                portCGpioSelect,     // GPIO: [0] line 3, [3:1] 10..8
    input  wire logic [3:0]                portCDirection,      // 1 = output, same order
    input  wire logic [3:0]                portCDataOut,        // GPIO output data
    output logic      [3:0]                portCDataIn,         // GPIO input data
    input  wire logic [15:0]               portCPullupEnable,   // Port C pull-up enables
    input  wire logic [15:0]               pullupDisableReg,    // Pull-up disable bits
    input  wire logic                      homePinIn,           // Home pin level
    output pin_mux_pkg::pinDrive_t         homePinDrive,        // Home pin level and enable
    output logic                           homePullupOn,        // Home pin pull-up
    output logic                           homeToDecoder,       // Decoder home input
    output pin_mux_pkg::homeFunc_t         homeFunction,        // Current home pin function
    input  wire logic                      timerBOut,           // Timer channel output
    input  wire logic                      timerBOe,            // Timer channel drives
    output logic                           timerBIn,            // Timer channel input
    input  wire logic                      spiMasterMode,       // SPI in master mode
    output logic                           spiSlaveSelected,    // Slave selected, active high
    output logic                           spiModeFault,        // Another master asserted
    input  wire logic [`PWM_PINS-1:0]      pwmLevel,            // PWM unit levels
    input  wire logic [`PWM_PINS-1:0]      pwmEnable,           // PWM unit output enables
    output logic      [`PWM_PINS-1:0]      pwmPinOut,           // PWM pin levels
    output logic      [`PWM_PINS-1:0]      pwmPinOe,            // PWM pin enables
    input  wire logic [`CS_PINS-1:0]       csPinIn,             // Current-status pin levels
    output logic      [`CS_PINS-1:0]       csPinOut,            // Current-status pin GPIO level
    output logic      [`CS_PINS-1:0]       csPinOe,             // Current-status pin GPIO enable
    output logic      [`CS_PINS-1:0]       csPullupOn,          // Current-status pull-ups
    output logic      [`CS_PINS-1:0]       csToPwm,             // Current status to PWM unit
    input  wire logic [`FAULT_PINS-1:0]    faultPinIn,          // Fault pin levels
    input  wire logic [`FAULT_PINS*6-1:0]  faultOutputMask,     // Fault i kills output j
    output logic      [`FAULT_PINS-1:0]    faultToPwm,          // Fault active, to PWM unit
    output logic                           faultPullupOn        // Fault pin pull-ups
);
    logic [`SYNC_WIDTH-1:0] syncLevel;
    logic                   homeLevel;
    logic [`CS_PINS-1:0]    csLevel;
    logic [`FAULT_PINS-1:0] faultActive;
    logic [`PWM_PINS-1:0]   pwmKill;

    pin_sync #(.WIDTH(`SYNC_WIDTH)) uSync (
        .mclk    (mclk),
        .rst     (rst),
        .pinIn   ({faultPinIn, csPinIn, homePinIn}),
        .syncOut (syncLevel)
    );

    assign homeLevel   = syncLevel[0];
    assign csLevel     = syncLevel[`CS_PINS:1];
    assign faultActive = syncLevel[`SYNC_WIDTH-1:`CS_PINS+1] ^ ~{`FAULT_PINS{`FAULT_ACTIVE_LEVEL}};

    // Fault kill gating per output.
    genvar j;
    generate
        for (j = 0; j < `PWM_PINS; j++) begin : gKill
            assign pwmKill[j] = |(faultActive & {faultOutputMask[12+j], faultOutputMask[6+j],
                                                 faultOutputMask[j]});
        end
    endgenerate

    pin_mux_pkg::homeFunc_t homeFunc_r, homeFunc_nxt;
    pin_mux_pkg::pinDrive_t homeDrive_r, homeDrive_nxt;
    logic homePull_r, homePull_nxt, homeDec_r, homeDec_nxt, timerIn_r, timerIn_nxt;
    logic slaveSel_r, slaveSel_nxt, modeFault_r, modeFault_nxt;
    logic [3:0] gpioIn_r, gpioIn_nxt;
    logic [`PWM_PINS-1:0] pwmOut_r, pwmOut_nxt, pwmOe_r, pwmOe_nxt;
    logic [`CS_PINS-1:0] csGpio_r, csGpio_nxt, csOut_r, csOut_nxt, csOe_r, csOe_nxt;
    logic [`CS_PINS-1:0] csPull_r, csPull_nxt, csPwm_r, csPwm_nxt;
    logic [`FAULT_PINS-1:0] fault_r, fault_nxt;
    logic faultPull_r, faultPull_nxt;

    always_comb begin
        // GPIO wins over the SPI select, which wins over the timer; the decoder is the fallback.
        if (portCGpioSelect[0]) begin
            homeFunc_nxt = pin_mux_pkg::HOME_GPIO;
        end else if (homeAlternateSelect) begin
            homeFunc_nxt = pin_mux_pkg::HOME_SPI_SELECT;
        end else if (timerBSelect) begin
            homeFunc_nxt = pin_mux_pkg::HOME_TIMER;
        end else begin
            homeFunc_nxt = pin_mux_pkg::HOME_DECODER;
        end
        homeDrive_nxt = '{level: 1'b0, enable: 1'b0};
        homeDec_nxt   = homeDec_r;
        timerIn_nxt   = 1'b0;
        slaveSel_nxt  = 1'b0;
        modeFault_nxt = 1'b0;
        // Decisions use the registered function so a pin never sees two owners in one cycle.
        case (homeFunc_r)
            pin_mux_pkg::HOME_DECODER: begin
                homeDec_nxt = homeLevel;
            end
            pin_mux_pkg::HOME_TIMER: begin
                homeDec_nxt   = homeLevel;
                timerIn_nxt   = homeLevel;
                homeDrive_nxt = '{level: timerBOut, enable: timerBOe};
            end
            pin_mux_pkg::HOME_SPI_SELECT: begin
                if (spiMasterMode) begin
                    modeFault_nxt = (homeLevel == `SPI_SELECT_ACTIVE_LEVEL);
                end else begin
                    slaveSel_nxt = (homeLevel == `SPI_SELECT_ACTIVE_LEVEL);
                end
            end
            pin_mux_pkg::HOME_GPIO: begin
                homeDrive_nxt = '{level: portCDataOut[0], enable: portCDirection[0]};
            end
            default: begin
                homeDec_nxt = homeLevel;
            end
        endcase
        homePull_nxt = portCPullupEnable[`PORTC_PULLUP_HOME_BIT];
        gpioIn_nxt   = {csLevel, homeLevel};
        csGpio_nxt   = portCGpioSelect[3:1];
        csPwm_nxt    = csLevel & ~csGpio_r;
        csOe_nxt     = csGpio_r & portCDirection[3:1];
        csOut_nxt    = portCDataOut[3:1];
        csPull_nxt   = portCPullupEnable[`PORTC_PULLUP_CS_BASE +: `CS_PINS];
        fault_nxt    = faultActive;
        faultPull_nxt = ~pullupDisableReg[`PULLDIS_GROUP_A_BIT];
        pwmOut_nxt   = pwmLevel;
        pwmOe_nxt    = pwmEnable & ~pwmKill;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            homeFunc_r  <= pin_mux_pkg::HOME_DECODER;
            homeDrive_r <= '{level: 1'b0, enable: 1'b0};
            homePull_r  <= `PULLUP_RST;
            homeDec_r   <= 1'b1;
            timerIn_r   <= 1'b0;
            slaveSel_r  <= 1'b0;
            modeFault_r <= 1'b0;
            gpioIn_r    <= 4'hF;
            csGpio_r    <= 3'h0;
            csPwm_r     <= 3'h0;
            csOe_r      <= 3'h0;
            csOut_r     <= 3'h0;
            csPull_r    <= {`CS_PINS{`PULLUP_RST}};
            fault_r     <= 3'h0;
            faultPull_r <= `PULLUP_RST;
            pwmOut_r    <= 6'h00;
            pwmOe_r     <= `PWM_OE_RST;
        end else begin
            homeFunc_r  <= homeFunc_nxt;
            homeDrive_r <= homeDrive_nxt;
            homePull_r  <= homePull_nxt;
            homeDec_r   <= homeDec_nxt;
            timerIn_r   <= timerIn_nxt;
            slaveSel_r  <= slaveSel_nxt;
            modeFault_r <= modeFault_nxt;
            gpioIn_r    <= gpioIn_nxt;
            csGpio_r    <= csGpio_nxt;
            csPwm_r     <= csPwm_nxt;
            csOe_r      <= csOe_nxt;
            csOut_r     <= csOut_nxt;
            csPull_r    <= csPull_nxt;
            fault_r     <= fault_nxt;
            faultPull_r <= faultPull_nxt;
            pwmOut_r    <= pwmOut_nxt;
            pwmOe_r     <= pwmOe_nxt;
        end
    end

    assign homeFunction     = homeFunc_r;
    assign homePinDrive     = homeDrive_r;
    assign homePullupOn     = homePull_r;
    assign homeToDecoder    = homeDec_r;
    assign timerBIn         = timerIn_r;
    assign spiSlaveSelected = slaveSel_r;
    assign spiModeFault     = modeFault_r;
    assign portCDataIn      = gpioIn_r;
    assign csToPwm          = csPwm_r;
    assign csPinOe          = csOe_r;
    assign csPinOut         = csOut_r;
    assign csPullupOn       = csPull_r;
    assign faultToPwm       = fault_r;
    assign faultPullupOn    = faultPull_r;
    assign pwmPinOut        = pwmOut_r;
    assign pwmPinOe         = pwmOe_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_SPI_ONLY_WITH_ALT: assert property (
        homeFunc_r == pin_mux_pkg::HOME_SPI_SELECT |-> $past(homeAlternateSelect)
            && !$past(portCGpioSelect[0]))
        else $error("Home pin in SPI select without the alternate bit.");

    AST_RESET_TO_DECODER: assert property (disable iff (1'b0)
        rst |-> homeFunc_r == pin_mux_pkg::HOME_DECODER && !homeDrive_r.enable)
        else $error("Home pin not on decoder function during reset.");

    AST_HOME_PULLUP_OFF: assert property (
        !portCPullupEnable[3] |=> !homePullupOn)
        else $error("Home pull-up still on after enable bit cleared.");

    AST_MASTER_ARBITRATION: assert property (
        homeFunc_r == pin_mux_pkg::HOME_SPI_SELECT && spiMasterMode && !homeLevel
            |=> spiModeFault && !spiSlaveSelected)
        else $error("Low select pin in master mode not flagged.");

    AST_SLAVE_SELECT: assert property (
        homeFunc_r == pin_mux_pkg::HOME_SPI_SELECT && !spiMasterMode
            |=> spiSlaveSelected == !$past(homeLevel) && !spiModeFault)
        else $error("Slave select does not follow the home pin.");

    AST_GPIO_DIRECTION: assert property (
        homeFunc_r == pin_mux_pkg::HOME_GPIO |=> homePinDrive.enable == $past(portCDirection[0])
            && homePinDrive.level == $past(portCDataOut[0]))
        else $error("Home pin GPIO drive does not follow direction.");

    AST_PWM_TRISTATE: assert property (disable iff (1'b0)
        rst |-> pwmPinOe == 6'h00)
        else $error("PWM pin enabled during reset.");

    AST_STATUS_TO_PWM: assert property (
        csGpio_r == 3'h0 ##1 csGpio_r == 3'h0 |-> csToPwm == $past(csLevel))
        else $error("Current status not passed to the PWM unit.");

    AST_STATUS_RESET_FUNC: assert property (disable iff (1'b0)
        rst |-> csGpio_r == 3'h0 && csPinOe == 3'h0)
        else $error("Current-status pins not on their function in reset.");

    AST_STATUS_PULLUP_OFF: assert property (
        portCPullupEnable[10:8] != 3'h7
            |=> (csPullupOn & ~$past(portCPullupEnable[10:8])) == 3'h0)
        else $error("Current-status pull-up still on after bits cleared.");

    AST_FAULT_KILLS_PWM: assert property (
        faultActive[0] && faultOutputMask[0] |=> !pwmPinOe[0])
        else $error("Fault did not disable the selected PWM output.");

    AST_FAULT_PULLUP_OFF: assert property (
        pullupDisableReg[0] |=> !faultPullupOn)
        else $error("Fault pull-ups still on with the disable bit set.");

    AST_HOME_TO_DECODER: assert property (
        homeFunc_r == pin_mux_pkg::HOME_DECODER |=> homeToDecoder == $past(homeLevel))
        else $error("Decoder home input does not follow the pin.");
endmodule

// ==== inc/pin_mux_map.svh ====
// Bit positions, reset values and polarities for the home/PWM pin function mux.
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH

`define PORTC_PULLUP_HOME_BIT   4'h3
`define PORTC_PULLUP_CS_BASE    4'h8
`define PULLDIS_GROUP_A_BIT     4'h0
`define PULLUP_RST              1'b1
`define PWM_OE_RST              6'h00
`define CS_PINS                 3
`define FAULT_PINS              3
`define PWM_PINS                6
`define FAULT_ACTIVE_LEVEL      1'b1
`define SPI_SELECT_ACTIVE_LEVEL 1'b0
`define SYNC_WIDTH              7

`endif

// ==== inc/pin_mux_pkg.sv ====
// Types shared by the home/PWM pin function mux.
package pin_mux_pkg;
    typedef enum logic [1:0] {
        HOME_DECODER,
        HOME_TIMER,
        HOME_SPI_SELECT,
        HOME_GPIO
    } homeFunc_t;

    typedef struct packed {
        logic level;
        logic enable;
    } pinDrive_t;
endpackage

// ==== src/pin_sync.sv ====
// Two-flop synchroniser for a vector of asynchronous pin levels.
module pin_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             mclk,   // System clock
    input  wire logic             rst,    // Asynchronous reset, active high
    input  wire logic [WIDTH-1:0] pinIn,  // Raw pin levels
    output logic      [WIDTH-1:0] syncOut // Levels after two flops
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gSync
            logic stage1_r;
            logic stage2_r;
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    stage1_r <= 1'b1;
                    stage2_r <= 1'b1;
                end else begin
                    stage1_r <= pinIn[i];
                    stage2_r <= stage1_r;
                end
            end
            assign syncOut[i] = stage2_r;
        end
    endgenerate
endmodule

// ==== tb/board_model.sv ====
// Board-side model that resolves the home and current-status pin wires.
module board_model (
    input  wire logic                   mclk,      // System clock
    input  wire pin_mux_pkg::pinDrive_t homeDrive, // Device drive on the home pin
    input  wire logic                   homePull,  // Home pull-up on
    input  wire logic                   extEn,     // Board drives the home pin
    input  wire logic                   extLevel,  // Board level on the home pin
    input  wire logic [2:0]             csOe,      // Device drives status pins
    input  wire logic [2:0]             csOut,     // Device levels on status pins
    input  wire logic [2:0]             csPull,    // Status pull-ups on
    input  wire logic [2:0]             csExtEn,   // Board drives status pins
    input  wire logic [2:0]             csExt,     // Board levels on status pins
    output logic                        homePin,   // Resolved home wire
    output logic      [2:0]             csPin      // Resolved status wires
);
    timeunit 1ns;
    timeprecision 1ps;
    // A floating wire without pull-up wanders, so a stale level never reads back.
    logic flip = 1'b0;
    always_ff @(posedge mclk) begin
        flip <= ~flip;
    end
    always_comb begin
        homePin = homeDrive.enable ? homeDrive.level : extEn ? extLevel : homePull ? 1'b1 : flip;
        for (int k = 0; k < 3; k++) begin
            csPin[k] = csOe[k] ? csOut[k] : csExtEn[k] ? csExt[k] : csPull[k] ? 1'b1 : flip;
        end
    end
endmodule

// ==== tb/test_home_pwm_pin_function_mux.sv ====
// Self-checking testbench for the home/PWM pin function mux.
module test_home_pwm_pin_function_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst = 1'b0, homeAlternateSelect, timerBSelect, homePinIn, homePullupOn;
    logic homeToDecoder, timerBOut, timerBOe, timerBIn, spiMasterMode, spiSlaveSelected;
    logic spiModeFault, faultPullupOn, extEn, extLevel;
    logic [3:0] portCGpioSelect, portCDirection, portCDataOut, portCDataIn;
    logic [15:0] portCPullupEnable, pullupDisableReg;
    logic [5:0] pwmLevel, pwmEnable, pwmPinOut, pwmPinOe, pat;
    logic [2:0] csPinIn, csPinOut, csPinOe, csPullupOn, csToPwm, faultPinIn, faultToPwm;
    logic [2:0] csExtEn, csExt;
    logic [17:0] faultOutputMask;
    pin_mux_pkg::pinDrive_t homePinDrive;
    pin_mux_pkg::homeFunc_t homeFunction;
    int n_fail = 0;
    int checked = 0;

    always #5 mclk = ~mclk;

    home_pwm_pin_function_mux u_home_pwm_pin_function_mux (
        .mclk, .rst, .homeAlternateSelect, .timerBSelect, .portCGpioSelect, .portCDirection,
        .portCDataOut, .portCDataIn, .portCPullupEnable, .pullupDisableReg, .homePinIn,
        .homePinDrive, .homePullupOn, .homeToDecoder, .homeFunction, .timerBOut, .timerBOe,
        .timerBIn, .spiMasterMode, .spiSlaveSelected, .spiModeFault, .pwmLevel, .pwmEnable,
        .pwmPinOut, .pwmPinOe, .csPinIn, .csPinOut, .csPinOe, .csPullupOn, .csToPwm,
        .faultPinIn, .faultOutputMask, .faultToPwm, .faultPullupOn);

    board_model u_board_model (
        .mclk, .homeDrive(homePinDrive), .homePull(homePullupOn), .extEn, .extLevel,
        .csOe(csPinOe), .csOut(csPinOut), .csPull(csPullupOn), .csExtEn, .csExt,
        .homePin(homePinIn), .csPin(csPinIn));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Inputs set after each step move 1 ns after the rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic final_report();
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A real edge on reset is needed, so the flops are cleared before the first clock edge.
    task automatic tReset();
        #1 rst = 1'b1;
        #1;
        check(pwmPinOe, 6'h00);
        check(homeFunction, pin_mux_pkg::HOME_DECODER);
        check({homePinDrive.enable, csPinOe}, 4'h0);
        homeAlternateSelect = 1'b0;
        portCGpioSelect = 4'h0;
        repeat (5) @(posedge mclk);
        #1 rst = 1'b0;
        step(3);
        check(homeFunction, pin_mux_pkg::HOME_DECODER);
    endtask

    task automatic tDecoder();
        extLevel = 1'b0;
        step(4);
        check(homeToDecoder, 1'b0);
        extLevel = 1'b1;
        step(4);
        check(homeToDecoder, 1'b1);
        portCPullupEnable[3] = 1'b0;
        step(2);
        check(homePullupOn, 1'b0);
        portCPullupEnable[3] = 1'b1;
        step(2);
        check(homePullupOn, 1'b1);
    endtask

    task automatic tSpi();
        homeAlternateSelect = 1'b1;
        extLevel = 1'b0;
        step(4);
        check(homeFunction, pin_mux_pkg::HOME_SPI_SELECT);
        check({homePinDrive.enable, spiSlaveSelected, spiModeFault}, 3'h2);
        spiMasterMode = 1'b1;
        step(4);
        check({spiSlaveSelected, spiModeFault}, 2'h1);
        extLevel = 1'b1;
        step(4);
        check(spiModeFault, 1'b0);
        // Timer drives the pin low, which must not look like a slave select.
        homeAlternateSelect = 1'b0;
        spiMasterMode = 1'b0;
        timerBSelect = 1'b1;
        timerBOe = 1'b1;
        extEn = 1'b0;
        step(5);
        check(homeFunction, pin_mux_pkg::HOME_TIMER);
        check({homePinDrive, timerBIn, spiSlaveSelected}, 4'h4);
        check(homeToDecoder, 1'b0);
        timerBOut = 1'b1;
        step(4);
        check({homePinDrive, timerBIn, homeToDecoder}, 4'hF);
        timerBSelect = 1'b0;
        timerBOe = 1'b0;
        timerBOut = 1'b0;
        extEn = 1'b1;
        step(4);
    endtask

    task automatic tGpio();
        homeAlternateSelect = 1'b1;
        for (int i = 0; i < 4; i++) begin
            portCGpioSelect = 4'h1 << i;
            portCDirection = 4'h1 << i;
            extEn = 1'b0;
            csExtEn = 3'h0;
            step(6);
            check(homeFunction, i == 0 ? 2'h3 : 2'h2);
            check({csPinOe, homePinDrive.enable}, 4'h1 << i);
            check(portCDataIn, 4'(~(4'h1 << i)));
            check(csToPwm & ((4'h1 << i) >> 1), 3'h0);
            portCDirection = 4'h0;
            extEn = 1'b1;
            extLevel = 1'b0;
            csExtEn = 3'h7;
            csExt = 3'h7;
            step(6);
            check({csPinOe, homePinDrive.enable, portCDataIn}, 8'h0E);
        end
        portCDataOut = 4'hA;
        step(2);
        check(csPinOut, 3'h5);
        portCDataOut = 4'h0;
        portCGpioSelect = 4'h0;
        homeAlternateSelect = 1'b0;
        step(4);
    endtask

    task automatic tStatus();
        csExt = 3'h5;
        step(4);
        check(csToPwm, 3'h5);
        csExt = 3'h2;
        step(4);
        check(csToPwm, 3'h2);
        for (int k = 0; k < 3; k++) begin
            portCPullupEnable = 16'hFFFF & ~(16'h0100 << k);
            step(2);
            check(csPullupOn, 3'h7 & ~(3'h1 << k));
        end
        portCPullupEnable = 16'hFFFF;
    endtask

    task automatic tFault();
        step(2);
        check({pwmPinOe, pwmPinOut}, 12'hFD5);
        for (int i = 0; i < 3; i++) begin
            pat = 6'h21 << i;
            faultOutputMask = 18'(pat) << (6 * i);
            faultPinIn = 3'h1 << i;
            step(4);
            check(faultToPwm, 3'h1 << i);
            check(pwmPinOe, 6'h3F & ~pat);
            faultPinIn = 3'h0;
            step(4);
            check(pwmPinOe, 6'h3F);
        end
        pullupDisableReg = 16'h0001;
        step(2);
        check(faultPullupOn, 1'b0);
        pullupDisableReg = 16'hFFFE;
        step(2);
        check(faultPullupOn, 1'b1);
    endtask

    initial begin
        {homeAlternateSelect, timerBSelect, timerBOut, timerBOe, spiMasterMode} = 5'h00;
        {portCGpioSelect, portCDirection, portCDataOut, pullupDisableReg} = 28'h0000000;
        portCPullupEnable = 16'hFFFF;
        {pwmEnable, pwmLevel, faultPinIn, faultOutputMask} = 33'h1FAA00000;
        {extEn, extLevel, csExtEn, csExt} = 8'hDC;
        tReset();
        tDecoder();
        tSpi();
        tGpio();
        tStatus();
        tFault();
        homeAlternateSelect = 1'b1;
        portCGpioSelect = 4'hF;
        step(3);
        tReset();
        final_report();
    end

    initial begin
        #20000;
        n_fail++;
        final_report();
    end
endmodule
